// ===== rss_exec.sv
// Execute unit for rotate-left-through-carry, the two subtracts and halt.
// Assumes one AHB-Lite master doing single word transfers; zero waits.
//
// Operation
// - Word 00_1101_dfff_ffff is rotate-left-carry; bit 7 dest, low 7 addr.
// - Rotate shifts left, old carry to bit 0, old bit 7 to carry.
// - Rotate result goes to accumulator if dest 0, else file register.
// - Halt word 00_0000_0110_0011 clears powerdown flag, sets timeout flag.
// - Halt clears watchdog counter and its prescaler.
// - After halt the core sleeps and executes no instructions until a 1 is written to bit 0 of the wake register.
// - Word 11_110x is literal minus accumulator, result to accumulator.
// - Word 00_0010 is register minus accumulator, dest selects target.
// - Subtract sets carry when the result is positive.
// - Subtract sets carry when the result is zero.
// - Subtract clears carry when the result wraps negative.
`default_nettype none

module rss_exec
  import rss_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        srst,
  // AHB-Lite slave request.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  // AHB-Lite slave answer.
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // ----------------------------------------------------------------
  // State and decode signals.
  // ----------------------------------------------------------------
  rss_state_t  st;
  rss_state_t  next_st;
  logic        take_addr;
  logic        exec;
  logic [13:0] iw;
  logic        is_rot;
  logic        is_subl;
  logic        is_subf;
  logic        is_halt;
  logic        dest_f;
  logic [6:0]  faddr;
  logic [7:0]  fval;
  logic [7:0]  minuend;
  logic [8:0]  diff;
  logic [4:0]  ndiff;
  logic [7:0]  rot_res;

  // Address phase is taken on any selected NONSEQ/SEQ with the bus ready.
  assign take_addr = hsel && htrans[1] && hready;

  // An instruction runs on a write to the instruction register.
  // It is ignored while asleep: the core oscillator is stopped.
  assign exec = st.dp_valid && st.dp_wr && (st.dp_ofs == INSTR_OFS)
                && !st.flags.asleep;

  // Decode of the fetched word.
  assign iw      = hwdata[13:0];
  assign is_rot  = (iw[13:8] == ROTATE_LEFT_CARRY_OP);
  assign is_subf = (iw[13:8] == REG_MINUS_ACC_OP);
  assign is_subl = (iw[13:9] == LITERAL_MINUS_ACC_OP);
  assign is_halt = (iw == HALT_OP);
  assign dest_f  = iw[DEST_BIT];
  assign faddr   = iw[6:0];
  assign fval    = st.file[faddr];

  // Datapath shared by both subtracts; bit 8 of diff is the borrow.
  assign minuend = is_subl ? iw[7:0] : fval;
  assign diff    = {1'b0, minuend} - {1'b0, st.acc};
  assign ndiff   = {1'b0, minuend[3:0]} - {1'b0, st.acc[3:0]};
  assign rot_res = {fval[6:0], st.flags.carry};

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  // Bus writes land first, then instruction effects; the read answer
  // is taken from the updated copy so a read right after a write sees
  // the written value.
  always_comb begin
    next_st = st;
    // Watchdog runs only while awake; prescaler carry bumps the count.
    if (!st.flags.asleep) begin
      next_st.prescaler = st.prescaler + 8'h01;
      if (st.prescaler == 8'hFF) begin
        next_st.watchdog_counter = st.watchdog_counter + 8'h01;
      end
    end
    // Data phase writes to control registers.
    if (st.dp_valid && st.dp_wr) begin
      unique case (st.dp_ofs)
        ACC_OFS: begin
          next_st.acc = hwdata[7:0];
        end
        STATUS_OFS: begin
          // Timeout, powerdown and sleep are read-only here.
          next_st.flags.carry            = hwdata[CARRY_POS];
          next_st.flags.half_borrow_flag = hwdata[HALF_POS];
          next_st.flags.zero             = hwdata[ZERO_POS];
        end
        FIDX_OFS: begin
          next_st.fidx = hwdata[6:0];
        end
        FDATA_OFS: begin
          next_st.file[st.fidx] = hwdata[7:0];
        end
        WAKE_OFS: begin
          if (hwdata[0]) begin
            next_st.flags.asleep = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Instruction effects, all in this one cycle.
    if (exec) begin
      if (is_rot) begin
        next_st.flags.carry = fval[7];
        if (dest_f) begin
          next_st.file[faddr] = rot_res;
        end else begin
          next_st.acc = rot_res;
        end
      end else if (is_subl || is_subf) begin
        next_st.flags.carry = !diff[8];
        next_st.flags.half_borrow_flag = !ndiff[4];
        next_st.flags.zero = (diff[7:0] == 8'h00);
        if (is_subf && dest_f) begin
          next_st.file[faddr] = diff[7:0];
        end else begin
          next_st.acc = diff[7:0];
        end
      end else if (is_halt) begin
        next_st.flags.powerdown_flag = 1'b0;
        next_st.flags.timeout_flag   = 1'b1;
        next_st.watchdog_counter     = WDOG_RST;
        next_st.prescaler            = PRE_RST;
        next_st.flags.asleep         = 1'b1;
      end
    end
    // Address phase capture and read answer.
    next_st.dp_valid = take_addr;
    if (take_addr) begin
      next_st.dp_wr  = hwrite;
      next_st.dp_ofs = haddr[7:0];
      next_st.hrdata = RD_RST;
      if (!hwrite) begin
        unique case (haddr[7:0])
          ACC_OFS:    next_st.hrdata[7:0] = next_st.acc;
          STATUS_OFS: next_st.hrdata[5:0] = next_st.flags;
          WDOG_OFS:   next_st.hrdata[15:0] =
                        {next_st.prescaler, next_st.watchdog_counter};
          FIDX_OFS:   next_st.hrdata[6:0] = next_st.fidx;
          FDATA_OFS:  next_st.hrdata[7:0] = next_st.file[next_st.fidx];
          default:    next_st.hrdata = RD_RST;
        endcase
      end
    end
    next_st.hreadyout = 1'b1;
    next_st.hresp     = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  // The file array is cleared too so reads after reset are defined.
  always_ff @(posedge clock) begin
    if (srst) begin
      st                  <= '0;
      st.acc              <= ACC_RST;
      st.flags            <= FLAGS_RST;
      st.watchdog_counter <= WDOG_RST;
      st.prescaler        <= PRE_RST;
      st.hrdata           <= RD_RST;
      st.hreadyout        <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata    = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp     = st.hresp;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  sequence s_halt;
    exec && is_halt;
  endsequence

  sequence s_asleep_cleared;
    st.flags.asleep && !st.flags.powerdown_flag && st.flags.timeout_flag;
  endsequence

  property p_rot_acc;
    @(posedge clock) disable iff (srst)
      exec && is_rot && !dest_f |=>
        st.acc == {$past(fval[6:0]), $past(st.flags.carry)};
  endproperty
  a_rot_acc: assert property (p_rot_acc)
    else $error("rotate to accumulator wrong");

  property p_rot_carry;
    @(posedge clock) disable iff (srst)
      exec && is_rot |=> st.flags.carry == $past(fval[7]) &&
        st.flags.zero == $past(st.flags.zero);
  endproperty
  a_rot_carry: assert property (p_rot_carry)
    else $error("rotate carry wrong");

  property p_rot_file;
    @(posedge clock) disable iff (srst)
      exec && is_rot && dest_f |=>
        st.file[$past(faddr)] == {$past(fval[6:0]), $past(st.flags.carry)}
        && st.acc == $past(st.acc);
  endproperty
  a_rot_file: assert property (p_rot_file)
    else $error("rotate to file wrong");

  property p_halt_flags;
    @(posedge clock) disable iff (srst)
      s_halt |=> s_asleep_cleared;
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("halt flags wrong");

  property p_halt_wdog;
    @(posedge clock) disable iff (srst)
      s_halt |=> st.watchdog_counter == 8'h00 && st.prescaler == 8'h00
        ##1 st.prescaler == 8'h00;
  endproperty
  a_halt_wdog: assert property (p_halt_wdog)
    else $error("halt did not clear watchdog");

  property p_sleep_hold;
    @(posedge clock) disable iff (srst)
      st.flags.asleep && st.dp_valid && st.dp_wr &&
        st.dp_ofs == INSTR_OFS |=> st.acc == $past(st.acc) &&
        st.flags.carry == $past(st.flags.carry);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("instruction ran while asleep");

  property p_subl;
    @(posedge clock) disable iff (srst)
      exec && is_subl |=>
        st.acc == 8'($past(iw[7:0]) - $past(st.acc));
  endproperty
  a_subl: assert property (p_subl)
    else $error("literal minus accumulator wrong");

  property p_sub_carry;
    @(posedge clock) disable iff (srst)
      exec && (is_subl || is_subf) |=>
        st.flags.carry == ($past(minuend) >= $past(st.acc));
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract carry wrong");

  property p_sub_zero;
    @(posedge clock) disable iff (srst)
      exec && (is_subl || is_subf) |=>
        st.flags.zero == ($past(minuend) == $past(st.acc)) &&
        st.flags.half_borrow_flag ==
          ($past(minuend[3:0]) >= $past(st.acc[3:0]));
  endproperty
  a_sub_zero: assert property (p_sub_zero)
    else $error("subtract zero or half flag wrong");

  property p_subf_file;
    @(posedge clock) disable iff (srst)
      exec && is_subf && dest_f |=>
        st.file[$past(faddr)] == 8'($past(fval) - $past(st.acc));
  endproperty
  a_subf_file: assert property (p_subf_file)
    else $error("register minus accumulator wrong");

  // A subtract into the accumulator must leave its source register alone.
  property p_subf_acc;
    @(posedge clock) disable iff (srst)
      exec && is_subf && !dest_f |=>
        st.acc == 8'($past(fval) - $past(st.acc)) &&
        st.file[$past(faddr)] == $past(fval);
  endproperty
  a_subf_acc: assert property (p_subf_acc)
    else $error("register minus accumulator to acc wrong");

  // The slave never stretches a transfer, so every instruction write
  // completes in its one data phase and always answers OKAY.
  property p_bus_okay;
    @(posedge clock) disable iff (srst)
      hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not ready or not okay");

endmodule : rss_exec

`default_nettype wire

// ===== rss_pkg.sv
// Constants and types for the rotate/subtract/halt execute block.
// Assumes a single 100 MHz core clock and an AHB-Lite register port.
`default_nettype none

package rss_pkg;

  // ----------------------------------------------------------------
  // Instruction encodings (14-bit words).
  // ----------------------------------------------------------------
  localparam logic [5:0]  ROTATE_LEFT_CARRY_OP = 6'h0D;
  localparam logic [5:0]  REG_MINUS_ACC_OP     = 6'h02;
  localparam logic [4:0]  LITERAL_MINUS_ACC_OP = 5'h1E;
  localparam logic [13:0] HALT_OP              = 14'h0063;
  localparam int          DEST_BIT             = 7;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] INSTR_OFS  = 8'h00;
  localparam logic [7:0] ACC_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] WDOG_OFS   = 8'h0C;
  localparam logic [7:0] FIDX_OFS   = 8'h10;
  localparam logic [7:0] FDATA_OFS  = 8'h14;
  localparam logic [7:0] WAKE_OFS   = 8'h18;

  // ----------------------------------------------------------------
  // Status field positions and values after reset.
  // ----------------------------------------------------------------
  localparam int CARRY_POS = 0;
  localparam int HALF_POS  = 1;
  localparam int ZERO_POS  = 2;
  localparam int PD_POS    = 3;
  localparam int TO_POS    = 4;
  localparam int SLEEP_POS = 5;
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [7:0]  WDOG_RST = 8'h00;
  localparam logic [7:0]  PRE_RST  = 8'h00;
  localparam logic [31:0] RD_RST   = 32'h0000_0000;

  // Status flags travel together.
  typedef struct packed {
    logic asleep;
    logic timeout_flag;
    logic powerdown_flag;
    logic zero;
    logic half_borrow_flag;
    logic carry;
  } rss_flags_t;

  localparam rss_flags_t FLAGS_RST = 6'h18;

  // Whole state of the execute block.
  typedef struct packed {
    logic [127:0][7:0] file;
    logic [7:0]        acc;
    rss_flags_t        flags;
    logic [7:0]        watchdog_counter;
    logic [7:0]        prescaler;
    logic [6:0]        fidx;
    logic              dp_valid;
    logic              dp_wr;
    logic [7:0]        dp_ofs;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
  } rss_state_t;

endpackage : rss_pkg

`default_nettype wire

// ===== tb_rotate_subtract_sleep_exec.sv
// Self-checking bench for the rotate, subtract and halt execute block.
// Assumes a zero-wait AHB-Lite slave and the register map of rss_pkg.
`default_nettype none

module tb_rotate_subtract_sleep_exec
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Clock, reset and bus signals.
  // ------------------------------------------------------------
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] rd;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  always #5 clock = ~clock;

  rss_exec i_rss_exec (
    .clock     (clock),
    .srst      (srst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  // ------------------------------------------------------------
  // Bus cycles and comparison.
  // ------------------------------------------------------------
  // Values read right after an edge are the ones sampled at it.
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
    check("bus response", {31'h0, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    bus(a, 1'b0, 32'h0000_0000, rd);
  endtask : rd_reg

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, seen);
      errors++;
    end
  endtask : check

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_reset_map();
    rd_reg(STATUS_OFS);
    check("status after reset", rd, 32'h0000_0018);
    rd_reg(ACC_OFS);
    check("acc after reset", rd, 32'h0000_0000);
    rd_reg(8'h1C);
    check("unmapped read", rd, 32'h0000_0000);
    // Sleep and the two power flags must not be writable by software.
    wr(STATUS_OFS, 32'h0000_003F);
    rd_reg(STATUS_OFS);
    check("status ro bits", rd, 32'h0000_001F);
    $display("test reset_map done");
  endtask : t_reset_map

  task automatic t_rotate();
    wr(FIDX_OFS, 32'h0000_0005);
    wr(FDATA_OFS, 32'h0000_00E6);
    wr(STATUS_OFS, 32'h0000_0004);
    wr(INSTR_OFS, {18'h0, ROTATE_LEFT_CARRY_OP, 1'b0, 7'h05});
    rd_reg(ACC_OFS);
    check("rotate to acc", rd, 32'h0000_00CC);
    rd_reg(STATUS_OFS);
    check("rotate flags", rd[2:0], 3'h5);
    rd_reg(FDATA_OFS);
    check("rotate source kept", rd, 32'h0000_00E6);
    // Carry is now set, so it must enter bit 0.
    wr(INSTR_OFS, {18'h0, ROTATE_LEFT_CARRY_OP, 1'b1, 7'h05});
    rd_reg(FDATA_OFS);
    check("rotate to file", rd, 32'h0000_00CD);
    rd_reg(ACC_OFS);
    check("rotate acc kept", rd, 32'h0000_00CC);
    $display("test rotate done");
  endtask : t_rotate

  task automatic t_sub_lit();
    logic [7:0] w [4] = '{8'h01, 8'h02, 8'h03, 8'h1F};
    logic [7:0] k [4] = '{8'h02, 8'h02, 8'h02, 8'h10};
    logic [7:0] r;
    logic [2:0] f;
    for (int i = 0; i < 4; i++) begin
      r = k[i] - w[i];
      // Zero, no nibble borrow, no byte borrow (inverted borrow).
      f = {r == 8'h00, k[i][3:0] >= w[i][3:0], k[i] >= w[i]};
      wr(ACC_OFS, {24'h0, w[i]});
      // The ignored opcode bit is toggled across the cases.
      wr(INSTR_OFS, {18'h0, LITERAL_MINUS_ACC_OP, i[0], k[i]});
      rd_reg(ACC_OFS);
      check("literal sub result", rd, {24'h0, r});
      rd_reg(STATUS_OFS);
      check("literal sub flags", rd[2:0], f);
    end
    $display("test sub_lit done");
  endtask : t_sub_lit

  task automatic t_sub_reg();
    wr(FIDX_OFS, 32'h0000_0009);
    wr(FDATA_OFS, 32'h0000_0003);
    wr(ACC_OFS, 32'h0000_0002);
    wr(INSTR_OFS, {18'h0, REG_MINUS_ACC_OP, 1'b1, 7'h09});
    rd_reg(FDATA_OFS);
    check("reg sub to file", rd, 32'h0000_0001);
    rd_reg(STATUS_OFS);
    check("reg sub flags pos", rd[2:0], 3'h3);
    wr(INSTR_OFS, {18'h0, REG_MINUS_ACC_OP, 1'b0, 7'h09});
    rd_reg(ACC_OFS);
    check("reg sub to acc", rd, 32'h0000_00FF);
    rd_reg(FDATA_OFS);
    check("reg sub file kept", rd, 32'h0000_0001);
    rd_reg(STATUS_OFS);
    check("reg sub flags neg", rd[2:0], 3'h0);
    $display("test sub_reg done");
  endtask : t_sub_reg

  task automatic t_halt();
    wr(INSTR_OFS, {18'h0, HALT_OP});
    rd_reg(STATUS_OFS);
    check("halt flags", rd[5:3], 3'h6);
    rd_reg(WDOG_OFS);
    check("halt watchdog", rd, 32'h0000_0000);
    // An instruction sent while asleep must have no effect.
    wr(ACC_OFS, 32'h0000_0055);
    wr(INSTR_OFS, {18'h0, ROTATE_LEFT_CARRY_OP, 1'b0, 7'h09});
    rd_reg(ACC_OFS);
    check("asleep no exec", rd, 32'h0000_0055);
    wr(WAKE_OFS, 32'h0000_0001);
    rd_reg(STATUS_OFS);
    check("wake flags", rd[5:3], 3'h2);
    $display("test halt done");
  endtask : t_halt

  // ------------------------------------------------------------
  // Verdict and sequencing.
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // A hang is cut short well past the roughly 120 cycles needed.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset_map();
    t_rotate();
    t_sub_lit();
    t_sub_reg();
    t_halt();
    test_done();
  end

endmodule : tb_rotate_subtract_sleep_exec

`default_nettype wire
